// >>> hdl/lsor_top.sv
// Answers the full-status and OTP-parameter queries of the bus master.
// Assumes a byte-level bus layer in front: it reports headers, received
// bytes and frame ends, and sends the bytes this block hands it.
// Notes on behaviour
// - OTP answer returns all OTP bytes in one frame, whatever the preparation.
// - OTP answer rides the 0x3D diagnostic id.
// - Type 7: direct id, command byte, address byte.
// - Reading header must equal protected 0x3D pattern.
// - OTP byte 1: oscillator and reference trims.
// - OTP byte 2: one, thermal trim, bandgap trim.
// - OTP byte 3: mode bit, pins, programmed address.
// - OTP byte 4: run and hold current.
// - OTP byte 5: maximum and minimum velocity.
// - OTP byte 6: position high, shaft, acceleration.
// - OTP bytes 7, 8: position low, modes, locks.
// - Status byte 4: shape, mode, shaft, acceleration.
// - Status byte 5: supply, fault and temperature flags.
// - Status byte 6: motion, switch, overcurrents, pump.
// - Status byte 7: ones, then communication errors.
// - Second status: address, positions, secure position.
// - Serving full status requests flag clearing.
// - Pin bits show live address pin state.
// - Type 8 preparation also accepted.
`timescale 1ns/1ns
`include "lsor_map.svh"

module lsor_top (
   // Clock and reset.
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   // Node identity.
   input  wire logic [6:0]         node_address,
   input  wire logic [4:0]         dyn_id,
   // Pins from outside the clock domain.
   input  wire logic [2:0]         hw_address_pins,
   input  wire logic               motion_switch_input,
   // Data from the other units.
   input  wire lsor_pkg::lsor_otp_s   otp_data,
   input  wire lsor_pkg::lsor_ram_s   ram_data,
   input  wire lsor_pkg::lsor_flags_s status_flags,
   input  wire logic [15:0]        actual_position,
   input  wire logic [15:0]        target_position,
   // Receive side of the bus layer.
   input  wire logic               hdr_valid,
   input  wire logic [7:0]         hdr_pid,
   input  wire logic               rx_valid,
   input  wire logic [7:0]         rx_byte,
   input  wire logic               rx_done,
   input  wire logic               rx_ok,
   // Transmit side of the bus layer.
   output logic                    tx_valid,
   input  wire logic               tx_ready,
   output logic [7:0]              tx_byte,
   // Events to the flag owners.
   output logic                    flag_clear,
   output logic                    resp_done
);

   // Three-stage pin synchronisers.
   logic [2:0] hw_s1_r;            // First stage, read by stage two only.
   logic [2:0] hw_s2_r;            // Second stage.
   logic [2:0] hw_s3_r;            // Third stage.
   logic [2:0] hw_live_r;          // Accepted pin state.
   logic       sw_s1_r;            // First stage of the switch.
   logic       sw_s2_r;            // Second stage of the switch.
   logic       sw_s3_r;            // Third stage of the switch.
   logic       sw_live_r;          // Accepted switch state.

   // Frame handling.
   lsor_pkg::lsor_state_e state_r;     // Current state.
   lsor_pkg::lsor_state_e state_nxt;   // Next state.
   lsor_pkg::lsor_prep_e  prep_kind_r; // Kind of preparing frame.
   logic [3:0]  rx_idx_r;          // Index of next data byte.
   logic [7:0]  rx_b1_r;           // Received data byte 1.
   logic [7:0]  rx_b2_r;           // Received data byte 2.
   logic [7:0]  rx_b3_r;           // Received data byte 3.
   logic        fill_ok_r;         // Filler bytes all ones so far.
   logic [1:0]  pend_r;            // Query awaiting its poll.
   lsor_pkg::lsor_resp_t resp_r;   // Latched answer bytes.
   logic [1:0]  serving_r;         // Query being answered.
   logic [3:0]  tx_idx_r;          // Index of byte on the output.
   logic [7:0]  csum_r;            // Running sum of sent bytes.

   // Header decoding shared by the state machine and capture.
   logic        hdr_is_read;       // Reading header with a query pending.
   logic        hdr_is_prep;       // Header opens a preparing frame.
   logic        prep_valid;        // Finished frame is a valid query.
   logic [6:0]  prep_cmd;          // Command code of that frame.
   logic        tx_take;           // Bus layer takes a byte.

   // Adds a byte with end-around carry, as the classic checksum does.
   function automatic logic [7:0] csum_add(input logic [7:0] a,
                                           input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   // Checks a byte that carries a one in bit 7 and a seven-bit value.
   function automatic logic marked_is(input logic [7:0] b,
                                      input logic [6:0] v);
      return (b == {`LSOR_MARK, v});
   endfunction

   // Pin synchroniser: three stages, a change counts once stages two
   // and three agree, which also filters single-cycle glitches.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hw_s1_r   <= 3'h0;
         hw_s2_r   <= 3'h0;
         hw_s3_r   <= 3'h0;
         hw_live_r <= 3'h0;
      end else begin
         hw_s1_r <= hw_address_pins;
         hw_s2_r <= hw_s1_r;
         hw_s3_r <= hw_s2_r;
         // Live pin state, never a stored copy.
         if (hw_s2_r == hw_s3_r) begin
            hw_live_r <= hw_s3_r;
         end
      end
   end

   // Switch input synchroniser, same scheme as the address pins.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sw_s1_r   <= 1'b0;
         sw_s2_r   <= 1'b0;
         sw_s3_r   <= 1'b0;
         sw_live_r <= 1'b0;
      end else begin
         sw_s1_r <= motion_switch_input;
         sw_s2_r <= sw_s1_r;
         sw_s3_r <= sw_s2_r;
         if (sw_s2_r == sw_s3_r) begin
            sw_live_r <= sw_s3_r;
         end
      end
   end

   // Header classification.
   always_comb begin
      // Only the exact protected pattern of 0x3D opens an answer.
      hdr_is_read = (hdr_pid == `LSOR_PID_READ) &&
                    (pend_r != `LSOR_PEND_NONE);
      // Type 7 uses our direct id, type 8 the fixed 0x3C header.
      hdr_is_prep = ((hdr_pid[`LSOR_ID_BIT5] == 1'b0) &&
                     (hdr_pid[4:0] == dyn_id)) ||
                    (hdr_pid == `LSOR_PID_PREP8);
   end

   // Validity of a finished preparing frame.
   always_comb begin
      prep_valid = 1'b0;
      prep_cmd   = rx_b1_r[6:0];
      if (prep_kind_r == lsor_pkg::LSOR_PREP7) begin
         // Command byte, address byte and checksum, both data bytes marked.
         prep_valid = rx_b1_r[7] &&
                      marked_is(rx_b2_r, node_address) &&
                      (rx_idx_r == `LSOR_T7_END);
      end else begin
         // Application byte, command, address, then ones.
         prep_cmd   = rx_b2_r[6:0];
         prep_valid = (rx_b1_r == `LSOR_APP_CMD) &&
                      rx_b2_r[7] &&
                      marked_is(rx_b3_r, node_address) &&
                      fill_ok_r &&
                      (rx_idx_r == `LSOR_T8_END);
      end
      prep_valid = prep_valid && rx_ok &&
                   ((prep_cmd == `LSOR_CMD_FULL) ||
                    (prep_cmd == `LSOR_CMD_OTP));
   end

   assign tx_take = (state_r == lsor_pkg::LSOR_SEND) && tx_ready;

   // Next state of the frame handler.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         lsor_pkg::LSOR_IDLE: begin
            // Preparation must come before the poll.
            if (hdr_valid && hdr_is_read) begin
               state_nxt = lsor_pkg::LSOR_SEND;
            end else if (hdr_valid && hdr_is_prep) begin
               state_nxt = lsor_pkg::LSOR_RECV;
            end
         end
         lsor_pkg::LSOR_RECV: begin
            // A new header aborts a frame that never ended.
            if (rx_done || hdr_valid) begin
               state_nxt = lsor_pkg::LSOR_IDLE;
            end
         end
         lsor_pkg::LSOR_SEND: begin
            // A new header means the layer gave up on our answer.
            if (hdr_valid) begin
               state_nxt = lsor_pkg::LSOR_IDLE;
            end else if (tx_take && (tx_idx_r == `LSOR_CSUM_IDX)) begin
               state_nxt = lsor_pkg::LSOR_IDLE;
            end
         end
         default: state_nxt = lsor_pkg::LSOR_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= lsor_pkg::LSOR_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Capture of the preparing frame's data bytes.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prep_kind_r <= lsor_pkg::LSOR_PREP7;
         rx_idx_r    <= `LSOR_B1;
         rx_b1_r     <= 8'h00;
         rx_b2_r     <= 8'h00;
         rx_b3_r     <= 8'h00;
         fill_ok_r   <= 1'b1;
      end else if (hdr_valid) begin
         // A new frame starts the count afresh.
         prep_kind_r <= (hdr_pid == `LSOR_PID_PREP8) ?
                        lsor_pkg::LSOR_PREP8 : lsor_pkg::LSOR_PREP7;
         rx_idx_r    <= `LSOR_B1;
         fill_ok_r   <= 1'b1;
      end else if ((state_r == lsor_pkg::LSOR_RECV) && rx_valid) begin
         // The index saturates so long frames are refused, not wrapped.
         if (rx_idx_r != `LSOR_IDX_SAT) begin
            rx_idx_r <= rx_idx_r + 4'h1;
         end
         if (rx_idx_r == `LSOR_B1) begin
            rx_b1_r <= rx_byte;
         end
         if (rx_idx_r == `LSOR_B2) begin
            rx_b2_r <= rx_byte;
         end
         if (rx_idx_r == `LSOR_B3) begin
            rx_b3_r <= rx_byte;
         end
         if ((rx_idx_r > `LSOR_B3) && (rx_idx_r <= `LSOR_LAST_DATA) && (rx_byte != `LSOR_FILL)) begin
            fill_ok_r <= 1'b0;
         end
      end
   end

   // Pending query: set by a valid preparation, advanced by answers.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pend_r <= `LSOR_PEND_NONE;
      end else if ((state_r == lsor_pkg::LSOR_RECV) && rx_done &&
                   prep_valid) begin
         // A fresh preparation overrides an unread second status.
         pend_r <= (prep_cmd == `LSOR_CMD_OTP) ?
                   `LSOR_PEND_OTP : `LSOR_PEND_FULL1;
      end else if (tx_take && (tx_idx_r == `LSOR_CSUM_IDX)) begin
         // Full status is two successive answers.
         pend_r <= (serving_r == `LSOR_PEND_FULL1) ?
                   `LSOR_PEND_FULL2 : `LSOR_PEND_NONE;
      end
   end

   // Answer assembly, latched when the poll header arrives so the
   // bytes stay coherent even if inputs move during the frame.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         resp_r    <= '0;
         serving_r <= `LSOR_PEND_NONE;
      end else if ((state_r == lsor_pkg::LSOR_IDLE) && hdr_valid &&
                   hdr_is_read) begin
         serving_r <= pend_r;
         unique case (pend_r)
            `LSOR_PEND_OTP: begin
               resp_r[0] <= {otp_data.osc_trim,
                             otp_data.ref_current_trim};
               resp_r[1] <= {`LSOR_MARK, otp_data.thermal_shutdown_trim,
                             otp_data.bandgap_trim};
               resp_r[2] <= {otp_data.address_mode_bit, hw_live_r,
                             otp_data.programmed_address};
               resp_r[3] <= {otp_data.irun, otp_data.ihold};
               resp_r[4] <= {otp_data.vmax, otp_data.vmin};
               resp_r[5] <= {otp_data.secure_position[10:8],
                             otp_data.shaft, otp_data.acc};
               resp_r[6] <= otp_data.secure_position[7:0];
               resp_r[7] <= {`LSOR_ZERO4, otp_data.step_resolution,
                             otp_data.lock_trim_bit,
                             otp_data.lock_config_bit};
            end
            `LSOR_PEND_FULL2: begin
               resp_r[0] <= {`LSOR_MARK, node_address};
               resp_r[1] <= actual_position[15:8];
               resp_r[2] <= actual_position[7:0];
               resp_r[3] <= target_position[15:8];
               resp_r[4] <= target_position[7:0];
               resp_r[5] <= ram_data.secure_position[7:0];
               resp_r[6] <= {`LSOR_ONES5,
                             ram_data.secure_position[10:8]};
               resp_r[7] <= `LSOR_FILL;
            end
            default: begin
               resp_r[0] <= {`LSOR_MARK, node_address};
               resp_r[1] <= {ram_data.irun, ram_data.ihold};
               resp_r[2] <= {ram_data.vmax, ram_data.vmin};
               resp_r[3] <= {ram_data.accel_shape,
                             ram_data.step_resolution,
                             ram_data.shaft, ram_data.acc};
               resp_r[4] <= {status_flags.logic_supply_reset_flag,
                             status_flags.step_loss_flag,
                             status_flags.electrical_defect_flag,
                             status_flags.undervoltage_flag,
                             status_flags.thermal_shutdown_flag,
                             status_flags.thermal_warning_flag,
                             status_flags.tinfo};
               resp_r[5] <= {status_flags.motion, sw_live_r,
                             status_flags.coil_x_overcurrent,
                             status_flags.coil_y_overcurrent,
                             `LSOR_MARK,
                             status_flags.charge_pump_fail};
               resp_r[6] <= {`LSOR_ONES4,
                             status_flags.timeout_error,
                             status_flags.data_error,
                             status_flags.header_error,
                             status_flags.bit_error};
               resp_r[7] <= `LSOR_FILL;
            end
         endcase
      end
   end

   // Transmit walk: eight data bytes then the inverted sum.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx_idx_r <= `LSOR_B1;
         tx_byte  <= 8'h00;
         csum_r   <= 8'h00;
      end else if (state_r != lsor_pkg::LSOR_SEND) begin
         tx_idx_r <= `LSOR_B1;
         csum_r   <= 8'h00;
         // Byte 1 comes straight from the inputs, since resp_r only holds them a cycle later.
         tx_byte  <= (pend_r == `LSOR_PEND_OTP) ?
                     {otp_data.osc_trim, otp_data.ref_current_trim} : {`LSOR_MARK, node_address};
      end else if (tx_take && (tx_idx_r != `LSOR_CSUM_IDX)) begin
         tx_idx_r <= tx_idx_r + 4'h1;
         csum_r   <= csum_add(csum_r, tx_byte);
         if (tx_idx_r == `LSOR_LAST_DATA) begin
            tx_byte <= ~csum_add(csum_r, tx_byte);
         end else begin
            tx_byte <= resp_r[tx_idx_r[2:0]];
         end
      end
   end

   // Handshake towards the bus layer is combinational.
   assign tx_valid = (state_r == lsor_pkg::LSOR_SEND);

   // End-of-answer events; the clear pulse goes out only after a
   // complete first status answer, so a broken frame keeps the flags.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         resp_done  <= 1'b0;
         flag_clear <= 1'b0;
      end else begin
         resp_done  <= tx_take && (tx_idx_r == `LSOR_CSUM_IDX);
         flag_clear <= tx_take && (tx_idx_r == `LSOR_CSUM_IDX) &&
                       (serving_r == `LSOR_PEND_FULL1);
      end
   end

endmodule // lsor_top

// >>> hdl/lsor_map.svh
// Holds the named constants of the status and OTP readback block.
// Assumes it is included by its bare name from the block's files.
`ifndef LSOR_MAP_SVH
`define LSOR_MAP_SVH
// Identifier bytes as seen on the bus (protected form).
`define LSOR_PID_READ     8'h7d
`define LSOR_PID_PREP8    8'h3c
// Direct identifier field: bit 5 low, bits 4..0 the node id.
`define LSOR_ID_BIT5      5
// Command codes carried in the low seven bits.
`define LSOR_CMD_FULL     7'h01
`define LSOR_CMD_OTP      7'h02
// Application command byte of the type 8 preparing frame.
`define LSOR_APP_CMD      8'h80
// Filler and marker values.
`define LSOR_FILL         8'hff
`define LSOR_ONES4        4'hf
`define LSOR_ONES5        5'h1f
`define LSOR_ZERO4        4'h0
`define LSOR_MARK         1'b1
// Byte positions inside frames (data byte n has index n).
`define LSOR_B1           4'h1
`define LSOR_B2           4'h2
`define LSOR_B3           4'h3
`define LSOR_LAST_DATA    4'h8
`define LSOR_CSUM_IDX     4'h9
`define LSOR_T7_END       4'h4
`define LSOR_T8_END       4'ha
`define LSOR_IDX_SAT      4'hb
// Pending query codes.
`define LSOR_PEND_NONE    2'h0
`define LSOR_PEND_FULL1   2'h1
`define LSOR_PEND_FULL2   2'h2
`define LSOR_PEND_OTP     2'h3
`endif

// >>> hdl/lsor_pkg.sv
// Holds the types of the status and OTP readback block.
// Assumes the constants header is compiled alongside.
package lsor_pkg;
   // Frame handling states, one-hot.
   typedef enum logic [2:0] {
      LSOR_IDLE = 3'h1,   // Waiting for a header.
      LSOR_RECV = 3'h2,   // Collecting a preparing frame.
      LSOR_SEND = 3'h4    // Sending an in-frame answer.
   } lsor_state_e;

   // Kind of frame being collected.
   typedef enum logic [1:0] {
      LSOR_PREP7 = 2'h1,  // Preparing frame on the direct id.
      LSOR_PREP8 = 2'h2   // Preparing frame on the 0x3c id.
   } lsor_prep_e;

   // Contents of the OTP memory.
   typedef struct packed {
      logic [3:0]  osc_trim;
      logic [3:0]  ref_current_trim;
      logic [2:0]  thermal_shutdown_trim;
      logic [3:0]  bandgap_trim;
      logic        address_mode_bit;
      logic [3:0]  programmed_address;
      logic [3:0]  irun;
      logic [3:0]  ihold;
      logic [3:0]  vmax;
      logic [3:0]  vmin;
      logic [10:0] secure_position;
      logic        shaft;
      logic [3:0]  acc;
      logic [1:0]  step_resolution;
      logic        lock_trim_bit;
      logic        lock_config_bit;
   } lsor_otp_s;

   // Live motion settings held in RAM.
   typedef struct packed {
      logic [3:0]  irun;
      logic [3:0]  ihold;
      logic [3:0]  vmax;
      logic [3:0]  vmin;
      logic        accel_shape;
      logic [1:0]  step_resolution;
      logic        shaft;
      logic [3:0]  acc;
      logic [10:0] secure_position;
   } lsor_ram_s;

   // Status flags from the motion, driver and bus units.
   typedef struct packed {
      logic       logic_supply_reset_flag;
      logic       step_loss_flag;
      logic       electrical_defect_flag;
      logic       undervoltage_flag;
      logic       thermal_shutdown_flag;
      logic       thermal_warning_flag;
      logic [1:0] tinfo;
      logic [2:0] motion;
      logic       coil_x_overcurrent;
      logic       coil_y_overcurrent;
      logic       charge_pump_fail;
      logic       timeout_error;
      logic       data_error;
      logic       header_error;
      logic       bit_error;
   } lsor_flags_s;

   // Array of the eight data bytes of an answer.
   typedef logic [7:0][7:0] lsor_resp_t;
endpackage : lsor_pkg

// >>> test/lsor_top_asserts.sv
// Checker of the answer handshake of the readback block.
// Assumes it is bound to lsor_top and sees only its ports.
`timescale 1ns/1ns
module lsor_top_asserts (
   // Clock and reset.
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   // Header side.
   input wire logic       hdr_valid,
   input wire logic [7:0] hdr_pid,
   // Answer side and events.
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic [7:0] tx_byte,
   input wire logic       flag_clear,
   input wire logic       resp_done
);
   // One clock domain, so one clock and one reset serve every property.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_start_cause: assert property ($rose(tx_valid) |-> $past(hdr_valid) && $past(hdr_pid) == 8'h7d)
      else $error("answer began without a read header");
   chk_other_pid: assert property (hdr_valid && hdr_pid != 8'h7d && !tx_valid |=> !tx_valid)
      else $error("answer began on a foreign identifier");
   chk_byte_hold: assert property (tx_valid && !tx_ready && !hdr_valid |=> tx_valid && $stable(tx_byte))
      else $error("answer byte changed before it was taken");
   chk_done_take: assert property (resp_done |-> $past(tx_valid) && $past(tx_ready))
      else $error("done pulse without a taken byte");
   chk_end_done: assert property ($fell(tx_valid) |-> resp_done || $past(hdr_valid))
      else $error("answer ended without done pulse");
   chk_done_pulse: assert property (resp_done |=> !resp_done)
      else $error("done pulse longer than one cycle");
   chk_clear_with: assert property (flag_clear |-> resp_done)
      else $error("flag clear outside a finished answer");
   chk_clear_pulse: assert property (flag_clear |=> !flag_clear [*8])
      else $error("flag clear repeated too soon");
endmodule // lsor_top_asserts
bind lsor_top lsor_top_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .hdr_valid(hdr_valid),
   .hdr_pid(hdr_pid), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
   .flag_clear(flag_clear), .resp_done(resp_done));

// >>> test/lsor_master.sv
// Bus master model: sends preparing frames and polls for answers.
// Assumes the byte-level handshake of the block's receive and send sides.
`timescale 1ns/1ns
module lsor_master (
   // Clock and stall control.
   input  wire logic       clk_sys,
   input  wire logic       slow,
   // Receive side of the block.
   output logic            hdr_valid,
   output logic [7:0]      hdr_pid,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   output logic            rx_done,
   output logic            rx_ok,
   // Send side of the block.
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [7:0] tx_byte,
   input  wire logic       resp_done,
   input  wire logic       flag_clear
);
   integer seed = 32'h1914; // Own stream, so stalls repeat run to run.
   // Quiet bus at time zero.
   initial begin
      {hdr_valid, rx_valid, rx_done, rx_ok, tx_ready} = 5'h00;
      {hdr_pid, rx_byte} = 16'h0000;
   end
   // Header, then data bytes with checksum last, then the frame end.
   task automatic send(input logic [7:0] pid, input logic [71:0] f, input int n, input logic ok);
      @(posedge clk_sys) #1;
      hdr_valid = 1'b1;
      hdr_pid = pid;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys) #1;
         hdr_valid = 1'b0;
         rx_valid = 1'b1;
         rx_byte = f[71-8*i -: 8];
      end
      @(posedge clk_sys) #1;
      rx_valid = 1'b0;
      rx_byte = ~rx_byte; // A released line must not keep showing the old byte.
      rx_done = 1'b1;
      rx_ok = ok;
      @(posedge clk_sys) #1;
      rx_done = 1'b0;
      rx_ok = ~ok;
   endtask
   // Poll header, then take bytes for a fixed window, stalling at random when slow.
   task automatic poll(input logic [7:0] pid, output logic [71:0] q, output logic dn, output logic fc);
      int n;
      {q, dn, fc, n} = '0;
      @(posedge clk_sys) #1;
      hdr_valid = 1'b1;
      hdr_pid = pid;
      @(posedge clk_sys) #1;
      hdr_valid = 1'b0;
      hdr_pid = ~pid;
      for (int t = 0; t < 60; t++) begin
         tx_ready = slow ? 1'($random(seed)) : 1'b1;
         if (tx_valid === 1'b1 && tx_ready) begin
            if (n < 9) q[71-8*n -: 8] = tx_byte; // Bytes past the ninth are counted but not stored or compared.
            n++;
         end
         dn |= (resp_done === 1'b1);
         fc |= (flag_clear === 1'b1);
         @(posedge clk_sys) #1;
      end
      tx_ready = 1'b0;
   endtask
endmodule // lsor_master

// >>> test/tb.sv
// Self-checking bench of the status and OTP readback block.
// Assumes the master model drives the bus side and random data the rest.
`timescale 1ns/1ns
module tb;
   logic                 clk_sys, sys_rst, slow, motion_switch_input; // Clock, reset, stall and switch.
   logic [6:0]           node_address;           // Node address.
   logic [4:0]           dyn_id;                 // Direct identifier.
   logic [2:0]           hw_address_pins;        // Raw address pins.
   lsor_pkg::lsor_otp_s   otp_data;               // OTP contents.
   lsor_pkg::lsor_ram_s   ram_data;               // RAM settings.
   lsor_pkg::lsor_flags_s status_flags;           // Status flags.
   logic [15:0]          actual_position, target_position; // Positions.
   logic                 hdr_valid, rx_valid, rx_done, rx_ok, tx_valid, tx_ready, flag_clear, resp_done;
   logic [7:0]           hdr_pid, rx_byte, tx_byte; // Bus bytes.
   integer               seed = 32'h1914;        // Fixed seed for repeatable data.
   int                   errors = 0;             // Mismatches.
   int                   compares = 0;           // Comparisons made.
   lsor_top uut (.clk_sys, .sys_rst, .node_address, .dyn_id, .hw_address_pins, .motion_switch_input,
      .otp_data, .ram_data, .status_flags, .actual_position, .target_position, .hdr_valid, .hdr_pid,
      .rx_valid, .rx_byte, .rx_done, .rx_ok, .tx_valid, .tx_ready, .tx_byte, .flag_clear, .resp_done);
   lsor_master mst (.clk_sys, .slow, .hdr_valid, .hdr_pid, .rx_valid, .rx_byte, .rx_done, .rx_ok,
      .tx_valid, .tx_ready, .tx_byte, .resp_done, .flag_clear);
   // Inverted sum with end-around carry; zero padding leaves it unchanged.
   function automatic logic [7:0] csum(input logic [63:0] d);
      logic [8:0] s;
      s = '0;
      for (int i = 0; i < 8; i++) begin
         s = s + 9'(d[63-8*i -: 8]);
         if (s[8]) s = s - 9'h0ff;
      end
      return ~s[7:0];
   endfunction
   // Eight data bytes followed by their checksum.
   function automatic logic [71:0] ans(input logic [63:0] d);
      return {d, csum(d)};
   endfunction
   // First full-status answer; ram bits 34..11 are currents, speeds, shape, mode, shaft, acceleration.
   function automatic logic [63:0] full1();
      return {1'b1, node_address, ram_data[34:11], status_flags[17:10], status_flags[9:7],
         motion_switch_input, status_flags[6:5], 1'b1, status_flags[4], 4'hf, status_flags[3:0], 8'hff};
   endfunction
   // Second answer: positions high byte first, secure position low byte first.
   function automatic logic [63:0] full2();
      return {1'b1, node_address, actual_position, target_position, ram_data.secure_position[7:0],
         5'h1f, ram_data.secure_position[10:8], 8'hff};
   endfunction
   // OTP answer with the live pin state in byte 3.
   function automatic logic [63:0] otp_exp();
      return {otp_data[55:48], 1'b1, otp_data[47:40], hw_address_pins, otp_data[39:20],
         otp_data.secure_position[10:8], otp_data.shaft, otp_data.acc, otp_data.secure_position[7:0],
         4'h0, otp_data[3:0]};
   endfunction
   task automatic check(input logic [71:0] got, input logic [71:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Preparing frame of either type; type 7 rides the direct identifier.
   task automatic prep(input logic [6:0] c, input logic [6:0] a, input logic t8, input logic ok);
      logic [63:0] d;
      d = t8 ? {8'h80, 1'b1, c, 1'b1, a, 40'hff_ffff_ffff} : {1'b1, c, 1'b1, a, 48'h0};
      if (t8) mst.send(8'h3c, ans(d), 9, ok);
      else mst.send({3'h6, dyn_id}, {d[63:48], csum(d), 48'h0}, 3, ok);
   endtask
   // Poll once and compare the answer and the done and clear pulses.
   task automatic ask(input logic [7:0] pid, input logic [71:0] exp, input logic [1:0] df);
      logic [71:0] q;
      logic        dn, fc;
      mst.poll(pid, q, dn, fc);
      check(q, exp);
      check(72'({dn, fc}), 72'(df));
   endtask
   task automatic shuffle();
      {otp_data, ram_data, status_flags} = 109'({$random(seed), $random(seed), $random(seed), $random(seed)});
      {actual_position, target_position} = $random(seed);
      {node_address, dyn_id, hw_address_pins, motion_switch_input, slow} = 17'($random(seed));
   endtask
   task automatic stop_test();
      if (errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Random data each round, with refused frames and a foreign poll among the queries.
   initial begin
      sys_rst = 1'b1;
      shuffle();
      repeat (5) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk_sys) #1;
         shuffle();
         repeat (4) @(posedge clk_sys);
         prep(7'h01, node_address, k[0], 1'b1);
         ask(8'h7d, ans(full1()), 2'h3);
         ask(8'h7d, ans(full2()), 2'h2);
         ask(8'h7d, 72'h0, 2'h0);
         prep(7'h02, node_address ^ 7'h01, k[1], 1'b1);
         prep(7'h02, node_address, k[1], 1'b0);
         ask(8'h7d, 72'h0, 2'h0);
         prep(7'h02, node_address, k[1], 1'b1);
         hw_address_pins = ~hw_address_pins;
         ask(8'h3d, 72'h0, 2'h0);
         ask(8'h7d, ans(otp_exp()), 2'h2);
      end
      stop_test();
   end
endmodule // tb
